/* File: verification/flash_program_status_logic_test.sv */
// Self-checking bench for the flash program controller
`timescale 1ns/1ps
`include "fps_params.svh"

module flash_program_status_logic_test;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, fail_mode, ce_b, we_b, oe_b;
  logic freset_b, dl_oe, busy_low, e;
  logic [7:0] paddr, dl_out, fl_dq;
  logic [31:0] pwdata, prdata, r;
  logic [19:0] faddr, a, a0;
  logic [15:0] lfsr = 16'h0046;
  logic [7:0] ref_mem [int];
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  // Ready line is the inverse of busy_low; data bus goes to whoever enables
  wire [7:0] dq_bus = dl_oe ? dl_out : fl_dq;
  wire rb_pin = ~busy_low;

  fps_ctrl uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b), .flash_addr(faddr),
    .flash_reset_b(freset_b), .data_lines_in(dq_bus), .data_lines_out(dl_out),
    .data_lines_oe(dl_oe), .ready_busy_pin(rb_pin));
  fps_flash_model flash (.ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .reset_b(freset_b),
    .addr(faddr), .dq_in(dq_bus), .fail_mode(fail_mode), .dq_out(fl_dq), .busy_low(busy_low));

  // ------------------------------------------------------------------
  // Bus tasks, comparisons and closing report
  // ------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_err(input logic got, input logic exp);
    chk_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task final_report;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Request held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One program run with every status field checked against the bench model
  task automatic prog_run(input logic [19:0] ad, input logic [7:0] d, input logic tgl,
                         input logic hw, input logic bad);
    logic [7:0] old;
    logic [7:0] want;
    int n;
    old = ref_mem.exists(ad) ? ref_mem[ad] : 8'hFF;
    want = bad ? old : (old & d);
    fail_mode <= bad;
    apb(1'b1, `FPS_OFF_ADDR, {12'h000, ad});
    apb(1'b1, `FPS_OFF_DATA, {24'h00_0000, d});
    apb(1'b1, `FPS_OFF_CTRL, {30'h0000_0000, tgl, 1'b1});
    apb(1'b1, `FPS_OFF_ADDR, {12'h000, ~ad});
    if (hw) begin
      repeat (60) @(posedge clk);
      apb(1'b1, `FPS_OFF_CTRL, 32'h0000_0008);
    end
    n = 0;
    do begin
      apb(1'b0, `FPS_OFF_STAT, 32'h0000_0000);
      n++;
    end while (r[`FPS_STAT_BUSY] !== 1'b0 && n < 3000);
    apb(1'b0, `FPS_OFF_ADDR, 32'h0000_0000);
    chk_reg(r, {12'h000, ad});
    apb(1'b0, `FPS_OFF_STAT, 32'h0000_0000);
    chk_reg(r & 32'h0000_003F, {26'h000_0000, hw, !bad && (want !== d), 1'b1, bad, !bad, 1'b0});
    apb(1'b0, `FPS_OFF_RDAT, 32'h0000_0000);
    if (!bad) chk_reg(r, {24'h00_0000, want});
    if (!bad) ref_mem[ad] = want;
    fail_mode <= 1'b0;
  endtask

  // Hang guard well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report;
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Main sequence: reset values, unmapped access, programs, timeout, hard abort
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fail_mode = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `FPS_OFF_STAT, 32'h0000_0000);
    chk_reg(r, 32'h0000_0008);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk_err(e, 1'b1);
    apb(1'b0, `FPS_OFF_CTRL, 32'h0000_0000);
    chk_err(e, 1'b0);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 2) ? a0 : {lfsr, lfsr[3:0]};
      if (i == 0) a0 = a;
      prog_run(a, (i == 2) ? 8'hFF : lfsr[15:8], i != 0, 1'b0, 1'b0);
    end
    lfsr = lfsr_next(lfsr);
    prog_run({lfsr, 4'h3}, lfsr[7:0], 1'b1, 1'b0, 1'b1);
    // Soft reset command from idle; the sticky fail flag must survive it
    apb(1'b1, `FPS_OFF_CTRL, 32'h0000_0004);
    do apb(1'b0, `FPS_OFF_STAT, 32'h0000_0000); while (r[`FPS_STAT_BUSY] !== 1'b0);
    chk_reg(r & 32'h0000_003F, 32'h0000_000C);
    lfsr = lfsr_next(lfsr);
    prog_run({4'h5, lfsr}, lfsr[15:8], 1'b0, 1'b1, 1'b0);
    final_report;
  end
endmodule // flash_program_status_logic_test

/* File: verification/fps_flash_model.sv */
// Behavioural parallel flash: program sequence, status bits, ready/busy
`timescale 1ns/1ps
`include "fps_params.svh"

module fps_flash_model #(
  parameter int BUSY_NS = 2000
) (
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic reset_b,
  input wire logic [19:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic fail_mode,
  output logic [7:0] dq_out,
  output logic busy_low
);
  // ------------------------------------------------------------------
  // Array and embedded algorithm state
  // ------------------------------------------------------------------
  logic [7:0] mem [int];
  logic [19:0] pa;
  logic [7:0] pd;
  logic [7:0] val = 8'h00;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic tmo = 1'b0;
  int step = 0;
  int gen = 0;
  wire rd_b = ce_b | oe_b;

  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // Commands latch on the write strobe rise; busy ignores every command until a timeout
  always @(posedge we_b) begin
    if (!ce_b && reset_b && (!busy || tmo)) begin
      if (dq_in == `FPS_RESET_DATA && step != 3) begin
        step = 0;
        busy = 1'b0;
        tmo = 1'b0;
      end else if (step == 3) begin
        pa = addr;
        pd = dq_in;
        busy = 1'b1;
        step = 0;
        gen++;
        fork
          begin : run
            automatic int g = gen;
            #(BUSY_NS);
            if (busy && g == gen && fail_mode) tmo = 1'b1;
            else if (busy && g == gen) begin
              mem[pa] = rd(pa) & pd;
              busy = 1'b0;
            end
          end
        join_none
      end else begin
        step = (step == 0 && addr == `FPS_UNL1_ADDR && dq_in == `FPS_UNL1_DATA) ? 1 :
               (step == 1 && addr == `FPS_UNL2_ADDR && dq_in == `FPS_UNL2_DATA) ? 2 :
               (step == 2 && addr == `FPS_UNL1_ADDR && dq_in == `FPS_SETUP_DATA) ? 3 : 0;
      end
    end
  end

  // Hardware reset kills the algorithm at once
  always @(negedge reset_b) begin
    busy = 1'b0;
    step = 0;
    tmo = 1'b0;
    gen++;
  end

  // Status while busy, array data otherwise; launched by the later read strobe fall
  always @(negedge rd_b) begin
    if (busy) begin
      tog = ~tog;
      val = {~pd[7], tog, tmo, 5'h00};
    end else begin
      val = rd(addr);
    end
  end

  // Released bus shows the inverse, so a stale byte can never pass for data
  assign dq_out = rd_b ? ~val : val;
  assign busy_low = busy;
endmodule // fps_flash_model

/* File: verilog/fps_bus_cycle.sv */
// One timed read or write cycle on the flash strobes
`timescale 1ns/1ps
`include "fps_params.svh"

module fps_bus_cycle
  import fps_pkg::*;
#(
  parameter int WP_CYC = `FPS_CYC_WP,
  parameter int RD_CYC = `FPS_CYC_RD
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic abort,
  input wire logic req_valid,
  input fps_cyc_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  output fps_pins_t pins,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe
);

  fps_phase_t phase_q;
  fps_cyc_t cur_q;
  logic [7:0] cnt_q;
  logic [7:0] low_cnt_q;

  // Only an idle engine takes a request
  assign req_ready = (phase_q == P_IDLE);

  // ----------------------------------------------------------------------
  // Phase sequence and strobe drive
  // ----------------------------------------------------------------------
  // Strobes come straight from flops so they never glitch; chip select
  // spans the whole cycle so the earlier-rising strobe is write/output, except on abort when all rise together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= P_IDLE;
      cur_q <= '0;
      cnt_q <= 8'h00;
      pins <= '{ce_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, addr: 20'h0_0000};
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else if (abort) begin
      phase_q <= P_IDLE;
      pins.ce_b <= 1'b1;
      pins.we_b <= 1'b1;
      pins.oe_b <= 1'b1;
      dq_oe <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_q)
        P_IDLE: begin
          if (req_valid) begin
            phase_q <= P_SETUP;
            cur_q <= req;
            pins.ce_b <= 1'b0;
            pins.addr <= req.addr;
            dq_out <= req.data;
            dq_oe <= req.wr;
          end
        end
        P_SETUP: begin
          phase_q <= P_STROBE;
          cnt_q <= cur_q.wr ? 8'(WP_CYC - 1) : 8'(RD_CYC - 1);
          pins.we_b <= !cur_q.wr;
          pins.oe_b <= cur_q.wr;
        end
        P_STROBE: begin
          if (cnt_q == 8'h00) begin
            phase_q <= P_HOLD;
            pins.we_b <= 1'b1;
            pins.oe_b <= 1'b1;
            if (!cur_q.wr) begin
              rdata <= dq_in;
            end
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        P_HOLD: begin
          phase_q <= P_IDLE;
          pins.ce_b <= 1'b1;
          dq_oe <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          phase_q <= P_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Counts how long write strobe stays low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 8'h00;
    end else if (!pins.we_b) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end else begin
      low_cnt_q <= 8'h00;
    end
  end

  a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_b)
    !(!pins.we_b && !pins.oe_b) && (pins.we_b || dq_oe))
    else $error("write and output strobes low together or undriven write");

  a_we_width: assert property (@(posedge clk) disable iff (!rst_b || abort)
    $rose(pins.we_b) && !$past(abort) |-> $past(low_cnt_q) == 8'(WP_CYC - 1) && !pins.ce_b)
    else $error("write strobe width wrong or chip select rose first");

endmodule // fps_bus_cycle

/* File: verilog/fps_ctrl.sv */
// Host-side program controller for a parallel flash, with APB register port
//
// Function
// - Program = two unlock writes, set-up command, then address/data write.
// - Hardware reset aborts programming; controller reissues full sequence afterwards.
// - Poll bit shows inverse of bit 7 until done; read program address.
// - Erase polling reads 0, then 1; erase not issued by this controller.
// - After poll bit turns true, re-read whole byte before trusting data.
// - Toggle check reads whole byte twice and compares; equal means done. Code compares only toggle bit 6 of the two reads.
// - Still toggling with timeout flag: check again, then fail and reset.
// - After stopping monitoring, restart toggle check from its first step.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fps_params.svh"

module fps_ctrl
  import fps_pkg::*;
#(
  parameter logic [19:0] UNL1_ADDR = `FPS_UNL1_ADDR,
  parameter logic [19:0] UNL2_ADDR = `FPS_UNL2_ADDR,
  parameter logic [7:0] UNL1_DATA = `FPS_UNL1_DATA,
  parameter logic [7:0] UNL2_DATA = `FPS_UNL2_DATA,
  parameter logic [7:0] SETUP_DATA = `FPS_SETUP_DATA,
  parameter logic [7:0] RESET_DATA = `FPS_RESET_DATA
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_ce_b,
  output logic flash_we_b,
  output logic flash_oe_b,
  output logic [19:0] flash_addr,
  output logic flash_reset_b,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic ready_busy_pin
);

  localparam int RP_CYC = `FPS_CYC_RP;
  localparam int RB_CYC = `FPS_CYC_RB;
  localparam int RP_M1 = RP_CYC - 1;

  fps_state_t state_q;
  logic [15:0] cnt_q;
  logic retry_q, rst_fail_q, prog_act_q, pend_q, toggle_q;
  logic done_q, fail_q, vfail_q, abort_q, rdy_q;
  logic [19:0] addr_q;
  logic [7:0] data_q, rd1_q, rd2_q;
  logic apb_wr, start_go, sw_go, hw_go, chk_ok, chk_tmo;
  logic cyc_valid, cyc_ready, cyc_done;
  logic [7:0] cyc_rdata;
  fps_cyc_t cyc_req;
  fps_pins_t pins;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // States that own one bus cycle
  function automatic logic is_op(input fps_state_t st);
    is_op = (st inside {S_UNL1, S_UNL2, S_SETUP, S_PROG, S_RD1, S_RD2, S_FINAL,
                        S_RSTCMD});
  endfunction

  // Bus cycle each state issues; polling and final reads use program address
  function automatic fps_cyc_t cyc_of(input fps_state_t st, input logic [19:0] a,
                                      input logic [7:0] d);
    fps_cyc_t c;
    c = '{wr: 1'b1, addr: a, data: d};
    case (st)
      S_UNL1: c = '{wr: 1'b1, addr: UNL1_ADDR, data: UNL1_DATA};
      S_UNL2: c = '{wr: 1'b1, addr: UNL2_ADDR, data: UNL2_DATA};
      S_SETUP: c = '{wr: 1'b1, addr: UNL1_ADDR, data: SETUP_DATA};
      S_RSTCMD: c = '{wr: 1'b1, addr: a, data: RESET_DATA};
      S_RD1, S_RD2, S_FINAL: c = '{wr: 1'b0, addr: a, data: 8'h00};
      default: c = '{wr: 1'b1, addr: a, data: d};
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr inside {`FPS_OFF_CTRL, `FPS_OFF_ADDR,
                   `FPS_OFF_DATA, `FPS_OFF_STAT, `FPS_OFF_RDAT});
  assign apb_wr = psel && penable && pwrite && !pslverr;
  // Start only taken when idle, so no command reaches a busy device
  assign start_go = apb_wr && paddr == `FPS_OFF_CTRL && pwdata[`FPS_CTRL_START]
                    && state_q == S_IDLE;
  assign sw_go = apb_wr && paddr == `FPS_OFF_CTRL && pwdata[`FPS_CTRL_SWRST]
                 && state_q == S_IDLE;
  assign hw_go = apb_wr && paddr == `FPS_OFF_CTRL && pwdata[`FPS_CTRL_HWRST];

  // Software-written settings; address and data are frozen while busy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_q <= `FPS_CTRL_RST;
      addr_q <= 20'h0_0000;
      data_q <= 8'h00;
    end else if (apb_wr && state_q == S_IDLE) begin
      case (paddr)
        `FPS_OFF_CTRL: toggle_q <= pwdata[`FPS_CTRL_TOGGLE];
        `FPS_OFF_ADDR: addr_q <= pwdata[19:0];
        `FPS_OFF_DATA: data_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data is loaded in the setup phase so it stands in the access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `FPS_OFF_CTRL: prdata <= {30'h0000_0000, toggle_q, 1'b0};
        `FPS_OFF_ADDR: prdata <= {12'h000, addr_q};
        `FPS_OFF_DATA: prdata <= {24'h00_0000, data_q};
        `FPS_OFF_STAT: prdata <= {26'h000_0000, abort_q, vfail_q, rdy_q, fail_q, done_q,
                                  state_q != S_IDLE};
        `FPS_OFF_RDAT: prdata <= {24'h00_0000, cyc_rdata};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------------
  // pend_q blocks a second request in the cycle where done is seen
  assign cyc_valid = is_op(state_q) && !pend_q && !hw_go;
  assign cyc_req = cyc_of(state_q, addr_q, data_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (hw_go || cyc_done) begin
      pend_q <= 1'b0;
    end else if (cyc_valid && cyc_ready) begin
      pend_q <= 1'b1;
    end
  end

  fps_bus_cycle #(
    .WP_CYC(`FPS_CYC_WP),
    .RD_CYC(`FPS_CYC_RD)
  ) u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .abort(hw_go),
    .req_valid(cyc_valid),
    .req(cyc_req),
    .req_ready(cyc_ready),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .dq_in(data_lines_in),
    .dq_out(data_lines_out),
    .dq_oe(data_lines_oe)
  );

  assign flash_ce_b = pins.ce_b;
  assign flash_we_b = pins.we_b;
  assign flash_oe_b = pins.oe_b;
  assign flash_addr = pins.addr;

  // ----------------------------------------------------------------------
  // Status evaluation
  // ----------------------------------------------------------------------
  // Poll mode: bit 7 true; toggle mode: toggle bit one equal in both reads
  assign chk_ok = toggle_q ? (rd1_q[`FPS_BIT_TOG] == rd2_q[`FPS_BIT_TOG])
                           : (rd1_q[`FPS_BIT_POLL] == data_q[`FPS_BIT_POLL]);
  assign chk_tmo = toggle_q ? rd2_q[`FPS_BIT_TMO] : rd1_q[`FPS_BIT_TMO];

  // Status reads kept for comparison
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd1_q <= 8'h00;
      rd2_q <= 8'h00;
    end else if (cyc_done && state_q == S_RD1) begin
      rd1_q <= cyc_rdata;
    end else if (cyc_done && state_q == S_RD2) begin
      rd2_q <= cyc_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Program sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      cnt_q <= 16'h0000;
      retry_q <= 1'b0;
      rst_fail_q <= 1'b0;
      prog_act_q <= 1'b0;
    end else if (hw_go) begin
      state_q <= S_HWRST;
      cnt_q <= 16'(RP_CYC - 1);
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start_go) begin
            state_q <= S_UNL1;
            prog_act_q <= 1'b1;
          end else if (sw_go) begin
            state_q <= S_RSTCMD;
            rst_fail_q <= 1'b0;
          end
        end
        S_UNL1: if (cyc_done) state_q <= S_UNL2;
        S_UNL2: if (cyc_done) state_q <= S_SETUP;
        S_SETUP: if (cyc_done) state_q <= S_PROG;
        S_PROG: begin
          if (cyc_done) begin
            state_q <= S_RD1;
            retry_q <= 1'b0;
          end
        end
        S_RD1: if (cyc_done) state_q <= toggle_q ? S_RD2 : S_CHECK;
        S_RD2: if (cyc_done) state_q <= S_CHECK;
        S_CHECK: begin
          if (chk_ok) begin
            state_q <= S_FINAL;
          end else if (retry_q) begin
            state_q <= S_RSTCMD;
            rst_fail_q <= 1'b1;
          end else begin
            // Every new look starts again at S_RD1, with a fresh pair of reads in toggle mode
            retry_q <= chk_tmo;
            state_q <= S_RD1;
          end
        end
        S_FINAL: begin
          if (cyc_done) begin
            state_q <= S_IDLE;
            prog_act_q <= 1'b0;
          end
        end
        S_RSTCMD: begin
          if (cyc_done) begin
            state_q <= S_IDLE;
            prog_act_q <= 1'b0;
          end
        end
        S_HWRST: begin
          if (cnt_q == 16'h0000) begin
            state_q <= S_HWWAIT;
            cnt_q <= 16'(RB_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        S_HWWAIT: begin
          // Aborted program is restarted from its first unlock write
          if (cnt_q == 16'h0000) begin
            state_q <= prog_act_q ? S_UNL1 : S_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Reset pin low for the whole reset window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_reset_b <= 1'b1;
    end else begin
      flash_reset_b <= !(hw_go || (state_q == S_HWRST && cnt_q != 16'h0000));
    end
  end

  // ----------------------------------------------------------------------
  // Sticky status and ready sample; a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      vfail_q <= 1'b0;
      abort_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= ready_busy_pin;
      if (state_q == S_FINAL && cyc_done) begin
        done_q <= 1'b1;
        vfail_q <= (cyc_rdata != data_q);
      end else if (start_go) begin
        done_q <= 1'b0;
        vfail_q <= 1'b0;
      end
      if (state_q == S_RSTCMD && cyc_done && rst_fail_q) begin
        fail_q <= 1'b1;
      end else if (start_go) begin
        fail_q <= 1'b0;
      end
      if (hw_go && prog_act_q) begin
        abort_q <= 1'b1;
      end else if (start_go) begin
        abort_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_setup_done;
    state_q == S_SETUP && cyc_done && !hw_go;
  endsequence

  a_prog_write: assert property (@(posedge clk) disable iff (!rst_b || hw_go)
    s_setup_done |=> state_q == S_PROG && cyc_valid && cyc_req.wr
      && cyc_req.addr == addr_q && cyc_req.data == data_q)
    else $error("program write does not follow set-up command");

  a_unlock_first: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_q == S_UNL1) |-> cyc_req.addr == UNL1_ADDR
      && cyc_req.data == UNL1_DATA && $past(state_q) inside {S_IDLE, S_HWWAIT})
    else $error("first unlock write has wrong address or data");

  a_poll_addr: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_valid && state_q inside {S_RD1, S_RD2} |-> !cyc_req.wr && cyc_req.addr == addr_q)
    else $error("status read not at program address");

  a_final_reread: assert property (@(posedge clk) disable iff (!rst_b || hw_go)
    state_q == S_CHECK && chk_ok |=> state_q == S_FINAL ##[1:40] (cyc_done && !cyc_req.wr))
    else $error("no full re-read after completion seen");

  a_toggle_pair: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_q == S_CHECK) && toggle_q |-> $past(state_q) == S_RD2)
    else $error("toggle check without two reads in a row");

  a_fail_reset: assert property (@(posedge clk) disable iff (!rst_b || hw_go)
    state_q == S_CHECK && retry_q && !chk_ok
      |=> state_q == S_RSTCMD ##[1:64] (state_q == S_IDLE && fail_q))
    else $error("failed operation not ended by reset command");

  a_rst_pulse: assert property (@(posedge clk) disable iff (!rst_b || hw_go)
    $fell(flash_reset_b) |-> ##[RP_M1:RP_M1] !flash_reset_b ##1 flash_reset_b)
    else $error("hardware reset pulse has wrong width");

  a_restart: assert property (@(posedge clk) disable iff (!rst_b || hw_go)
    state_q == S_HWWAIT && cnt_q == 16'h0000 && prog_act_q |=> state_q == S_UNL1)
    else $error("aborted program not reissued after reset");

endmodule // fps_ctrl

/* File: verilog/fps_params.svh */
// Offsets, field positions, command values and timing counts of the program controller
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// ----------------------------------------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------------------------------------
`define FPS_OFF_CTRL 8'h00
`define FPS_OFF_ADDR 8'h04
`define FPS_OFF_DATA 8'h08
`define FPS_OFF_STAT 8'h0C
`define FPS_OFF_RDAT 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FPS_CTRL_START 0
`define FPS_CTRL_TOGGLE 1
`define FPS_CTRL_SWRST 2
`define FPS_CTRL_HWRST 3
`define FPS_STAT_BUSY 0
`define FPS_STAT_DONE 1
`define FPS_STAT_FAIL 2
`define FPS_STAT_RDY 3
`define FPS_STAT_VFAIL 4
`define FPS_STAT_ABORT 5
`define FPS_BIT_POLL 7
`define FPS_BIT_TOG 6
`define FPS_BIT_TMO 5

// ----------------------------------------------------------------------
// Reset values and default command table
// ----------------------------------------------------------------------
`define FPS_CTRL_RST 1'b0
`define FPS_UNL1_ADDR 20'h0_0001
`define FPS_UNL2_ADDR 20'h0_0002
`define FPS_UNL1_DATA 8'h01
`define FPS_UNL2_DATA 8'h02
`define FPS_SETUP_DATA 8'h03
`define FPS_RESET_DATA 8'h04

// ----------------------------------------------------------------------
// Timing: least times in ns, rounded up to 5 ns cycles
// ----------------------------------------------------------------------
`define FPS_CLK_NS 5
`define FPS_T_WP_NS 35
`define FPS_T_RD_NS 70
`define FPS_T_RP_NS 500
`define FPS_T_RB_NS 200
`define FPS_CYC_WP ((`FPS_T_WP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_CYC_RD ((`FPS_T_RD_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_CYC_RP ((`FPS_T_RP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_CYC_RB ((`FPS_T_RB_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)

`endif

/* File: verilog/fps_pkg.sv */
// Types shared by the program controller and its bus cycle engine
package fps_pkg;

  // Controller sequence states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_UNL1 = 4'h1,
    S_UNL2 = 4'h2,
    S_SETUP = 4'h3,
    S_PROG = 4'h4,
    S_RD1 = 4'h5,
    S_RD2 = 4'h6,
    S_CHECK = 4'h7,
    S_FINAL = 4'h8,
    S_RSTCMD = 4'h9,
    S_HWRST = 4'hA,
    S_HWWAIT = 4'hB
  } fps_state_t;

  // Phases of one flash bus cycle
  typedef enum logic [1:0] {
    P_IDLE = 2'h0,
    P_SETUP = 2'h1,
    P_STROBE = 2'h2,
    P_HOLD = 2'h3
  } fps_phase_t;

  // Strobes and address toward the flash
  typedef struct packed {
    logic ce_b;
    logic we_b;
    logic oe_b;
    logic [19:0] addr;
  } fps_pins_t;

  // One bus cycle request
  typedef struct packed {
    logic wr;
    logic [19:0] addr;
    logic [7:0] data;
  } fps_cyc_t;

endpackage
